// File: shared/tsm_cfg.svh
// Constants of the temperature measurement sequencer
`ifndef TSM_CFG_SVH
`define TSM_CFG_SVH

// Register byte offsets on the APB side
`define TSM_OFS_START    8'h00
`define TSM_OFS_STOP     8'h04
`define TSM_OFS_MODE     8'h08
`define TSM_OFS_FLGCLR   8'h0C
`define TSM_OFS_STATUS   8'h10
`define TSM_OFS_MASK     8'h14
`define TSM_OFS_RESULT   8'h18
`define TSM_OFS_STATE    8'h1C

// Field positions
`define TSM_BIT_START    0
`define TSM_BIT_STOP     0
`define TSM_BIT_CONT     0
`define TSM_FLG_END      0
`define TSM_FLG_IGN      2
`define TSM_FLG_MASK     3'h5
`define TSM_MODE_CONT    8'h01
`define TSM_FLGCLR_ALL   8'h05

// Reset values
`define TSM_RST_MODE     1'b0
`define TSM_RST_MASK     3'h0

// Sequence lengths in sensor-clock states
`define TSM_PREP_STATES  3
`define TSM_CONV_STATES  512
`define TSM_FIRST_STATES 515

// Timing: one conversion lasts 9.984 ms, core clock period 5 ns
`define TSM_CONV_TIME_NS 9984000
`define TSM_CLK_PERIOD_NS 5
`define TSM_STATE_CYCLES (`TSM_CONV_TIME_NS / `TSM_CLK_PERIOD_NS / `TSM_CONV_STATES)

`endif

// File: shared/tsm_pkg.sv
// Types of the temperature measurement sequencer
`default_nettype none
package tsm_pkg;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_PREP = 3'h2,
        ST_CONV = 3'h4
    } seq_state_t;
    // Status flag vector
    typedef logic [2:0] flag_vec_t;
endpackage : tsm_pkg
`default_nettype wire

// File: shared/tick_if.sv
// Link between the sequencer and its sensor-state tick generator
`default_nettype none
interface tick_if;
    logic run;   // Tick generator runs while high
    logic tick;  // One-cycle pulse per sensor-clock state
    modport gen  (input run, output tick);
    modport user (output run, input tick);
endinterface : tick_if
`default_nettype wire

// File: hdl/state_tick_gen.sv
// Divider producing one tick per sensor-clock state
`default_nettype none
module state_tick_gen #(
    parameter int STATE_CYCLES = 3900
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_nrst,
    // Link to sequencer
    tick_if.gen       tk
);
    localparam int CW = $clog2(STATE_CYCLES);
    localparam logic [CW-1:0] LAST = CW'(STATE_CYCLES - 1);

    logic [CW-1:0] cnt_reg;   // Cycles in current state
    logic [CW-1:0] cnt_next;
    logic          tick_reg;  // Registered tick
    logic          tick_next;

    // Restart from zero whenever stopped so state edges align to start
    always_comb begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (!tk.run) begin
            cnt_next = '0;
        end else if (cnt_reg == LAST) begin
            cnt_next  = '0;
            tick_next = 1'b1;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    // Registers only
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tk.tick = tick_reg;
endmodule : state_tick_gen
`default_nettype wire

// File: hdl/temp_sensor_measure_seq.sv
// Temperature sensor measurement sequencer with APB registers
//
// Functional notes
// - Three-state stabilisation after each start
// - Each conversion lasts 512 states
// - One-time result at state 515, then stop
// - One-time mode ends by itself
// - Continuous: first at 515, then every 512
// - Stop bit ends any running measurement
// - Mode value 0x01 selects continuous mode
// - Flag clear value 0x05 clears flags
//
// The implementer's own choices: the address map and register access over APB.
`include "tsm_cfg.svh"
`default_nettype none
module temp_sensor_measure_seq #(
    parameter int CODE_W       = 12,
    parameter int STATE_CYCLES = `TSM_STATE_CYCLES
) (
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_nrst,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Sensor analog front end code, asynchronous
    input  wire logic [CODE_W-1:0] i_sensor_code,
    // Status
    output logic                   o_busy,
    output logic                   o_irq
);
    import tsm_pkg::*;

    localparam logic [8:0] PREP_LAST = 9'(`TSM_PREP_STATES - 1);
    localparam logic [8:0] CONV_LAST = 9'(`TSM_CONV_STATES - 1);

    // Address match, used by decode and by the write strobes
    function automatic logic adr_hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction : adr_hit

    tick_if u_tick_link ();  // Tick link

    state_tick_gen #(
        .STATE_CYCLES (STATE_CYCLES)
    ) u_tick_gen (
        .i_core_clk (i_core_clk),
        .i_nrst     (i_nrst),
        .tk         (u_tick_link.gen)
    );

    // Two-stage synchroniser for the sensor code
    logic [CODE_W-1:0] code_meta_reg;  // First stage, read by second only
    logic [CODE_W-1:0] code_sync_reg;  // Safe to use bit by bit
    logic [CODE_W-1:0] code_prev_reg;  // Previous synchronised sample
    logic [CODE_W-1:0] code_good_reg;  // Code seen equal on two edges
    // The code is a word with no handshake: bits may land on different
    // edges, so a capture only trusts a value two samples agree on
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            code_meta_reg <= '0;
            code_sync_reg <= '0;
            code_prev_reg <= '0;
            code_good_reg <= '0;
        end else begin
            code_meta_reg <= i_sensor_code;
            code_sync_reg <= code_meta_reg;
            code_prev_reg <= code_sync_reg;
            // Settled word only
            if (code_sync_reg == code_prev_reg) begin
                code_good_reg <= code_sync_reg;
            end
        end
    end

    // ---------------- APB decode ----------------
    logic        pready_reg;      // Access-phase ready
    logic        pready_next;
    logic        pslverr_reg;     // Unmapped address
    logic        pslverr_next;
    logic [31:0] prdata_reg;      // Read data
    logic [31:0] prdata_next;
    logic        setup;           // Setup phase seen
    logic        mapped;          // Address is known
    logic        wr;              // Write completes this edge
    logic        wr_start;
    logic        wr_stop;
    logic        wr_mode;
    logic        wr_clr;
    logic        wr_mask;

    assign setup  = i_psel && !i_penable;
    assign mapped = adr_hit(i_paddr, `TSM_OFS_START)  || adr_hit(i_paddr, `TSM_OFS_STOP)
                 || adr_hit(i_paddr, `TSM_OFS_MODE)   || adr_hit(i_paddr, `TSM_OFS_FLGCLR)
                 || adr_hit(i_paddr, `TSM_OFS_STATUS) || adr_hit(i_paddr, `TSM_OFS_MASK)
                 || adr_hit(i_paddr, `TSM_OFS_RESULT) || adr_hit(i_paddr, `TSM_OFS_STATE);
    // Writes act only at the completing edge and never on an error
    assign wr       = i_psel && i_penable && pready_reg && i_pwrite && !pslverr_reg;
    assign wr_start = wr && adr_hit(i_paddr, `TSM_OFS_START) && i_pwdata[`TSM_BIT_START];
    assign wr_stop  = wr && adr_hit(i_paddr, `TSM_OFS_STOP) && i_pwdata[`TSM_BIT_STOP];
    assign wr_mode  = wr && adr_hit(i_paddr, `TSM_OFS_MODE);
    // Status is write-one-to-clear; the flag clear register works alike
    assign wr_clr   = wr && (adr_hit(i_paddr, `TSM_OFS_FLGCLR)
                          || adr_hit(i_paddr, `TSM_OFS_STATUS));
    assign wr_mask  = wr && adr_hit(i_paddr, `TSM_OFS_MASK);

    // ---------------- Sequencer ----------------
    seq_state_t        st_reg;     // Sequencer state
    seq_state_t        st_next;
    logic [8:0]        cnt_reg;    // States spent in current phase
    logic [8:0]        cnt_next;
    logic [CODE_W-1:0] res_reg;    // Last result
    logic [CODE_W-1:0] res_next;
    logic              evt_done;   // Result written this cycle
    logic              evt_ign;    // Start ignored this cycle
    logic              mode_reg;   // Continuous when set
    logic              mode_next;

    assign u_tick_link.run = (st_reg != ST_IDLE);

    // Next state of the sequencer
    always_comb begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        res_next = res_reg;
        evt_done = 1'b0;
        evt_ign  = 1'b0;
        if (wr_stop) begin
            // Stop takes priority and idles at once
            st_next  = ST_IDLE;
            cnt_next = '0;
        end else begin
            unique case (st_reg)
                ST_IDLE: begin
                    if (wr_start) begin
                        st_next  = ST_PREP;
                        cnt_next = '0;
                    end
                end
                ST_PREP: begin
                    evt_ign = wr_start;
                    if (u_tick_link.tick) begin
                        if (cnt_reg == PREP_LAST) begin
                            st_next  = ST_CONV;
                            cnt_next = '0;
                        end else begin
                            cnt_next = cnt_reg + 1'b1;
                        end
                    end
                end
                ST_CONV: begin
                    evt_ign = wr_start;
                    if (u_tick_link.tick) begin
                        if (cnt_reg == CONV_LAST) begin
                            // Last state of the conversion
                            evt_done = 1'b1;
                            res_next = code_good_reg;
                            cnt_next = '0;
                            // One-time stops itself, continuous reconverts
                            st_next  = mode_reg ? ST_CONV : ST_IDLE;
                        end else begin
                            cnt_next = cnt_reg + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------- Registers and APB answer ----------------
    flag_vec_t sts_reg;    // Sticky event flags
    flag_vec_t sts_next;
    flag_vec_t mask_reg;   // Interrupt enables
    flag_vec_t mask_next;
    flag_vec_t flg_set;
    flag_vec_t flg_clr;
    logic      irq_next;
    logic      busy_next;

    // Register file next values; a set beats a clear in the same cycle
    always_comb begin
        flg_set = '0;
        flg_set[`TSM_FLG_END] = evt_done;
        flg_set[`TSM_FLG_IGN] = evt_ign;
        flg_clr   = wr_clr ? (i_pwdata[2:0] & `TSM_FLG_MASK) : '0;
        sts_next  = (sts_reg & ~flg_clr) | flg_set;
        mask_next = wr_mask ? (i_pwdata[2:0] & `TSM_FLG_MASK) : mask_reg;
        // Only bit 0 of the mode word matters, 0x01 is continuous
        mode_next = wr_mode ? i_pwdata[`TSM_BIT_CONT] : mode_reg;
        irq_next  = |(sts_next & mask_next);
        busy_next = (st_next != ST_IDLE);
        // No wait state: ready and error are raised in the first access-phase cycle
        pready_next  = setup;
        pslverr_next = setup && !mapped;
        prdata_next  = '0;
        if (setup && !i_pwrite) begin
            if (adr_hit(i_paddr, `TSM_OFS_MODE)) begin
                prdata_next[`TSM_BIT_CONT] = mode_reg;
            end else if (adr_hit(i_paddr, `TSM_OFS_STATUS)) begin
                prdata_next[2:0] = sts_reg;
            end else if (adr_hit(i_paddr, `TSM_OFS_MASK)) begin
                prdata_next[2:0] = mask_reg;
            end else if (adr_hit(i_paddr, `TSM_OFS_RESULT)) begin
                prdata_next[CODE_W-1:0] = res_reg;
            end else if (adr_hit(i_paddr, `TSM_OFS_STATE)) begin
                prdata_next[2:0] = st_reg;
            end
        end
    end

    // Sequencer, register file and APB answer registers
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg      <= ST_IDLE;
            cnt_reg     <= '0;
            res_reg     <= '0;
            mode_reg    <= `TSM_RST_MODE;
            sts_reg     <= '0;
            mask_reg    <= `TSM_RST_MASK;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
            o_irq       <= 1'b0;
            o_busy      <= 1'b0;
        end else begin
            st_reg      <= st_next;
            cnt_reg     <= cnt_next;
            res_reg     <= res_next;
            mode_reg    <= mode_next;
            sts_reg     <= sts_next;
            mask_reg    <= mask_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
            o_irq       <= irq_next;
            o_busy      <= busy_next;
        end
    end

    assign o_pready  = pready_reg;
    assign o_pslverr = pslverr_reg;
    assign o_prdata  = prdata_reg;

    // ---------------- Checking helpers ----------------
    logic [31:0] h_ticks_reg;  // Ticks since start
    logic [31:0] h_last_reg;   // Tick count at last result
    logic        h_any_reg;    // A result seen since start
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            h_ticks_reg <= '0;
            h_last_reg  <= '0;
            h_any_reg   <= 1'b0;
        end else if (st_reg == ST_IDLE) begin
            h_ticks_reg <= '0;
            h_last_reg  <= '0;
            h_any_reg   <= 1'b0;
        end else begin
            h_ticks_reg <= h_ticks_reg + 32'(u_tick_link.tick);
            if (evt_done) begin
                h_last_reg <= h_ticks_reg + 32'h1;
                h_any_reg  <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    AST_PREP_THREE: assert property (
        st_reg == ST_CONV && $past(st_reg) == ST_PREP |-> h_ticks_reg == 32'(`TSM_PREP_STATES))
        else $error("conversion did not begin after three states");
    AST_FIRST_515: assert property (
        evt_done && !h_any_reg |-> h_ticks_reg == 32'(`TSM_FIRST_STATES - 1))
        else $error("first result not at state 515");
    AST_EVERY_512: assert property (
        evt_done && h_any_reg |-> h_ticks_reg - h_last_reg == 32'(`TSM_CONV_STATES - 1))
        else $error("result spacing not 512 states");
    AST_ONE_TIME_END: assert property (
        evt_done && !mode_reg |=> st_reg == ST_IDLE ##1 !o_busy)
        else $error("one-time measurement did not stop");
    AST_CONT_GOES_ON: assert property (
        evt_done && mode_reg |=> st_reg == ST_CONV && cnt_reg == '0)
        else $error("continuous measurement did not restart");
    AST_STOP_IDLE: assert property (
        wr_stop |=> st_reg == ST_IDLE ##1 !o_busy)
        else $error("stop did not idle the sequencer");
    AST_MODE_CONT: assert property (
        wr_mode && i_pwdata[7:0] == `TSM_MODE_CONT |=> mode_reg)
        else $error("mode value 0x01 did not select continuous");
    AST_FLAG_CLEAR: assert property (
        wr_clr && i_pwdata[7:0] == `TSM_FLGCLR_ALL && !evt_done && !evt_ign
        |=> sts_reg == 3'h0)
        else $error("flag clear 0x05 left a flag set");
    AST_RESULT_FLAG: assert property (
        evt_done |=> res_reg == $past(code_good_reg) && sts_reg[`TSM_FLG_END]
        ##1 o_irq == |(mask_reg & sts_reg))
        else $error("result or end flag not stored");
    AST_START_IGNORED: assert property (
        wr_start && st_reg != ST_IDLE && !evt_done
        |=> st_reg != ST_IDLE && sts_reg[`TSM_FLG_IGN])
        else $error("start while busy was not ignored");

    COV_ONE_TIME: cover property (evt_done && !mode_reg);
    COV_CONT_SECOND: cover property (evt_done && h_any_reg);
    COV_STOP_CONV: cover property (wr_stop && st_reg == ST_CONV);
    COV_IGNORED: cover property (evt_ign);
endmodule : temp_sensor_measure_seq
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the temperature measurement sequencer
`include "tsm_cfg.svh"
`default_nettype none
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("ERROR %s exp %h got %h", nm, e, g); \
    end \
end
module testbench;
    import tsm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // Short state length keeps a 515-state run near 2k cycles
    localparam int SC = 4;
    localparam int LIM = 600 * SC;
    // Table row: register read after reset
    typedef struct {
        logic [7:0]  addr;
        logic [31:0] data;
        logic        err;
    } row_t;
    // Design stimulus and outputs
    logic        i_core_clk = 1'b0;
    logic        i_nrst = 1'b0;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [11:0] i_sensor_code = 12'hA5C;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        o_busy;
    logic        o_irq;
    // Bookkeeping
    int          err_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    int          irq_t = 0;
    logic        irq_d = 1'b0;
    logic [31:0] rd;
    logic        se;
    int          t0;
    int          t1;
    int          n;
    row_t        rows[10];
    // Device under test
    temp_sensor_measure_seq #(.CODE_W(12), .STATE_CYCLES(SC)) uut (
        .i_core_clk   (i_core_clk),
        .i_nrst       (i_nrst),
        .i_psel       (i_psel),
        .i_penable    (i_penable),
        .i_pwrite     (i_pwrite),
        .i_paddr      (i_paddr),
        .i_pwdata     (i_pwdata),
        .o_prdata     (o_prdata),
        .o_pready     (o_pready),
        .o_pslverr    (o_pslverr),
        .i_sensor_code(i_sensor_code),
        .o_busy       (o_busy),
        .o_irq        (o_irq)
    );
    // 200 MHz clock
    always #2.5 i_core_clk = ~i_core_clk;
    // Cycle count and interrupt rise time stamp
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (o_irq === 1'b1 && irq_d !== 1'b1) begin
            irq_t = cyc;
        end
        irq_d <= o_irq;
    end
    // Verdict and end of run
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        // No fixed wait: only the watchdog ends a transfer that never completes
        do begin
            @(posedge i_core_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        se = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        // Idle edge, so the next setup never overwrites this release
        @(posedge i_core_clk);
    endtask : apb
    // Wait a number of rising edges
    task automatic clks(input int c);
        repeat (c) @(posedge i_core_clk);
    endtask : clks
    // Hang guard, well above the expected run of about 8.5k cycles
    initial begin
        #300000;
        err_count++;
        stop_test();
    end
    // Main sequence
    initial begin
        rows = '{'{`TSM_OFS_START, 32'h0, 1'b0}, '{`TSM_OFS_STOP, 32'h0, 1'b0},
                 '{`TSM_OFS_MODE, 32'h0, 1'b0}, '{`TSM_OFS_FLGCLR, 32'h0, 1'b0},
                 '{`TSM_OFS_STATUS, 32'h0, 1'b0}, '{`TSM_OFS_MASK, 32'h0, 1'b0},
                 '{`TSM_OFS_RESULT, 32'h0, 1'b0}, '{`TSM_OFS_STATE, 32'(ST_IDLE), 1'b0},
                 '{8'h20, 32'h0, 1'b1}, '{8'hFC, 32'h0, 1'b1}};
        clks(5);
        // Outputs quiet during reset
        `CHK("rst_busy", 1'b0, o_busy)
        `CHK("rst_irq", 1'b0, o_irq)
        i_nrst <= 1'b1;
        clks(1);
        // Reset values and unmapped places
        foreach (rows[i]) begin
            apb(1'b0, rows[i].addr, 32'h0);
            `CHK("reg_data", rows[i].data, rd)
            `CHK("reg_err", rows[i].err, se)
        end
        // One-time run, interrupt masked
        apb(1'b1, `TSM_OFS_FLGCLR, 32'(`TSM_FLGCLR_ALL));
        apb(1'b1, `TSM_OFS_START, 32'h1);
        clks(1);
        `CHK("ot_busy", 1'b1, o_busy)
        n = 1;
        while (o_busy !== 1'b0 && n < LIM) begin
            clks(1);
            n++;
        end
        `CHK("ot_len", 1'b1, n >= 515 * SC && n <= 515 * SC + 2)
        clks(4);
        `CHK("ot_irq_masked", 1'b0, o_irq)
        apb(1'b0, `TSM_OFS_RESULT, 32'h0);
        `CHK("ot_result", 32'h00000A5C, rd)
        apb(1'b0, `TSM_OFS_STATUS, 32'h0);
        `CHK("ot_status", 32'h1, rd)
        apb(1'b1, `TSM_OFS_MASK, 32'h1);
        clks(3);
        `CHK("irq_unmask", 1'b1, o_irq)
        apb(1'b1, `TSM_OFS_STATUS, 32'h1);
        clks(3);
        `CHK("irq_clear", 1'b0, o_irq)
        // Continuous run with an ignored second start
        apb(1'b1, `TSM_OFS_MODE, 32'(`TSM_MODE_CONT));
        apb(1'b0, `TSM_OFS_MODE, 32'h0);
        `CHK("mode_rb", 32'h1, rd)
        apb(1'b1, `TSM_OFS_START, 32'h1);
        t0 = cyc;
        irq_t = 0;
        n = 0;
        while (irq_t == 0 && n < LIM) begin
            clks(1);
            n++;
        end
        t1 = irq_t;
        n = t1 - t0;
        `CHK("ct_first", 1'b1, n >= 515 * SC && n <= 515 * SC + 3)
        i_sensor_code <= 12'h3C1;
        apb(1'b1, `TSM_OFS_STATUS, 32'h1);
        apb(1'b1, `TSM_OFS_START, 32'h1);
        n = 0;
        while (irq_t == t1 && n < LIM) begin
            clks(1);
            n++;
        end
        `CHK("ct_period", 512 * SC, irq_t - t1)
        apb(1'b0, `TSM_OFS_RESULT, 32'h0);
        `CHK("ct_result", 32'h000003C1, rd)
        apb(1'b0, `TSM_OFS_STATUS, 32'h0);
        `CHK("ct_ignored", 32'h5, rd)
        apb(1'b1, `TSM_OFS_FLGCLR, 32'(`TSM_FLGCLR_ALL));
        apb(1'b0, `TSM_OFS_STATUS, 32'h0);
        `CHK("flg_clear", 32'h0, rd)
        apb(1'b1, `TSM_OFS_STOP, 32'h1);
        clks(2);
        `CHK("ct_stop", 1'b0, o_busy)
        apb(1'b0, `TSM_OFS_STATE, 32'h0);
        `CHK("ct_idle", 32'(ST_IDLE), rd)
        // One-time run stopped during conversion
        apb(1'b1, `TSM_OFS_MODE, 32'h0);
        apb(1'b1, `TSM_OFS_START, 32'h1);
        apb(1'b0, `TSM_OFS_STATE, 32'h0);
        `CHK("st_prep", 32'(ST_PREP), rd)
        clks(50);
        apb(1'b0, `TSM_OFS_STATE, 32'h0);
        `CHK("st_conv", 32'(ST_CONV), rd)
        apb(1'b1, `TSM_OFS_STOP, 32'h1);
        clks(2);
        `CHK("ot_stop", 1'b0, o_busy)
        clks(515 * SC + 10);
        apb(1'b0, `TSM_OFS_STATUS, 32'h0);
        `CHK("ot_no_result", 32'h0, rd)
        `CHK("ot_no_irq", 1'b0, o_irq)
        // Reset in mid-run returns sequencer and mode to idle values
        apb(1'b1, `TSM_OFS_MODE, 32'(`TSM_MODE_CONT));
        apb(1'b1, `TSM_OFS_START, 32'h1);
        clks(20);
        `CHK("mr_busy", 1'b1, o_busy)
        i_nrst <= 1'b0;
        clks(2);
        `CHK("mr_rst_busy", 1'b0, o_busy)
        i_nrst <= 1'b1;
        clks(1);
        apb(1'b0, `TSM_OFS_STATE, 32'h0);
        `CHK("mr_idle", 32'(ST_IDLE), rd)
        apb(1'b0, `TSM_OFS_MODE, 32'h0);
        `CHK("mr_mode", 32'h0, rd)
        stop_test();
    end
endmodule : testbench
`default_nettype wire
